// >>> fetch_watchdog_pkg.sv
// Package: register map, fields, keys and reset values of the fetch watchdog
package fetch_watchdog_pkg;
  localparam logic [3:0] ADDR_FIRST_KEY = 4'h0;
  localparam logic [3:0] ADDR_CLEAR_KEY = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h3;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h4;
  localparam logic [3:0] ADDR_TIMEOUT_LOW = 4'h5;
  localparam logic [3:0] ADDR_TIMEOUT_HIGH = 4'h6;
  localparam logic [3:0] ADDR_WINDOW_LOW = 4'h7;
  localparam logic [3:0] ADDR_WINDOW_HIGH = 4'h8;
  localparam logic [3:0] ADDR_HOLD = 4'h9;
  localparam logic [7:0] FIRST_KEY_VALUE = 8'h40;
  localparam logic [7:0] CLEAR_KEY_VALUE = 8'h08;
  localparam int FIRST_KEY_LSB = 8;
  localparam int SECOND_KEY_LSB = 0;
  localparam int STAT_FIRST_ERR_BIT = 7;
  localparam int STAT_SECOND_ERR_BIT = 6;
  localparam int STAT_EVENT_BIT = 5;
  localparam int STAT_WINDOW_BIT = 0;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [15:0] HOLD_RESET = 16'h0000;
endpackage : fetch_watchdog_pkg

// >>> fetch_watchdog.sv
// Fetch watchdog: clear key sequence, status flags and counter readback
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// - Clear key after correct first key clears both keys and counter.
// - Wrong clear key sets second error, stores value for one cycle, then the event clears both keys.
// - Second key field clears on watchdog reset event.
// - Wrong first key sets status bit 7.
// - Wrong second key sets status bit 6.
// - Status bit 5 sets when counter reaches timeout value.
// - Wrong key before next counter increment also sets event bit.
// - Error and event bits not software writable, reset to zero.
// - Status bit 0 reads clear window open state.
// - Low count register reads counter bits 15:0.
// - High count register reads counter bits 31:16.
// - Low timeout register mirrors configured timeout bits 15:0.
// - High timeout register mirrors configured timeout bits 31:16.
// - Low window register mirrors configured window bits 15:0.
// - High window register mirrors configured window bits 31:16.
// - First key is 0x40; other values set first error.
// - Counter advances per fetch until timeout match.
// - Counter is 32 bits; match value from two 16-bit words.
// - Hold register captures upper count only on count readback.
module fetch_watchdog (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_fetch,
  input wire logic i_clear_window_open,
  input wire logic [15:0] i_timeout_fuse_low,
  input wire logic [15:0] i_timeout_fuse_high,
  input wire logic [15:0] i_window_fuse_low,
  input wire logic [15:0] i_window_fuse_high,
  output logic [15:0] o_rdata,
  output logic o_reset_request,
  output logic o_watchdog_event
);

  //--------------------------------------------------------------
  // State registers
  //--------------------------------------------------------------
  logic [7:0] first_key_field_reg;
  logic [7:0] second_key_field_reg;
  logic first_key_error_reg;
  logic second_key_error_reg;
  logic watchdog_event_reg;
  logic [31:0] fetch_count_reg;
  logic [15:0] held_upper_count_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic reset_request_reg;

  //--------------------------------------------------------------
  // Decode nets
  //--------------------------------------------------------------
  logic [31:0] timeout_config_value;
  logic [31:0] window_config_value;
  logic [31:0] fetch_count_inc;
  logic [7:0] first_key_written;
  logic [7:0] second_key_written;
  logic wr_first;
  logic wr_second;
  logic first_key_armed;
  logic bad_first;
  logic bad_second;
  logic good_clear;
  logic timeout_low_match;
  logic timeout_high_match;
  logic timeout_hit;
  logic event_cause;
  logic key_clear;
  logic count_step;
  logic rd_count_low;
  logic rd_count_high;
  logic count_read;
  logic [15:0] first_key_word;
  logic [15:0] second_key_word;
  logic [15:0] status_word;

  //--------------------------------------------------------------
  // Configuration words
  //--------------------------------------------------------------
  assign timeout_config_value = {i_timeout_fuse_high, i_timeout_fuse_low};
  assign window_config_value = {i_window_fuse_high, i_window_fuse_low};
  assign timeout_low_match = (fetch_count_reg[15:0] == i_timeout_fuse_low);
  assign timeout_high_match = (fetch_count_reg[31:16] == i_timeout_fuse_high);
  assign timeout_hit = timeout_low_match && timeout_high_match;

  //--------------------------------------------------------------
  // Key decode
  //--------------------------------------------------------------
  assign wr_first = i_wr && (i_addr == fetch_watchdog_pkg::ADDR_FIRST_KEY);
  assign wr_second = i_wr && (i_addr == fetch_watchdog_pkg::ADDR_CLEAR_KEY);
  assign first_key_written = i_wdata[fetch_watchdog_pkg::FIRST_KEY_LSB +: 8];
  assign second_key_written = i_wdata[fetch_watchdog_pkg::SECOND_KEY_LSB +: 8];
  assign first_key_armed = (first_key_field_reg == fetch_watchdog_pkg::FIRST_KEY_VALUE);
  assign bad_first = wr_first && (first_key_written != fetch_watchdog_pkg::FIRST_KEY_VALUE);
  assign good_clear = wr_second && (second_key_written == fetch_watchdog_pkg::CLEAR_KEY_VALUE) && first_key_armed;
  assign bad_second = wr_second && !good_clear;

  //--------------------------------------------------------------
  // Event, counter and readback decode
  //--------------------------------------------------------------
  assign event_cause = timeout_hit || bad_first || bad_second;
  assign key_clear = i_rst || watchdog_event_reg;
  assign fetch_count_inc = fetch_count_reg + 32'h0000_0001;
  assign count_step = i_fetch && !timeout_hit;
  assign rd_count_low = i_rd && (i_addr == fetch_watchdog_pkg::ADDR_COUNT_LOW);
  assign rd_count_high = i_rd && (i_addr == fetch_watchdog_pkg::ADDR_COUNT_HIGH);
  assign count_read = rd_count_low || rd_count_high;

  //--------------------------------------------------------------
  // First key field
  //--------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (key_clear)
    begin
      first_key_field_reg <= fetch_watchdog_pkg::KEY_RESET;
    end
    else if (good_clear)
    begin
      first_key_field_reg <= fetch_watchdog_pkg::KEY_RESET;
    end
    else if (wr_first)
    begin
      first_key_field_reg <= first_key_written;
    end
  end

  //--------------------------------------------------------------
  // Second key field, cleared by the event the cycle after a wrong first key
  //--------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (key_clear)
    begin
      second_key_field_reg <= fetch_watchdog_pkg::KEY_RESET;
    end
    else if (good_clear)
    begin
      second_key_field_reg <= fetch_watchdog_pkg::KEY_RESET;
    end
    else if (wr_second)
    begin
      second_key_field_reg <= second_key_written;
    end
  end

  //--------------------------------------------------------------
  // First key error flag
  //--------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      first_key_error_reg <= 1'b0;
    end
    else if (bad_first)
    begin
      first_key_error_reg <= 1'b1;
    end
  end

  //--------------------------------------------------------------
  // Second key error flag
  //--------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      second_key_error_reg <= 1'b0;
    end
    else if (bad_second)
    begin
      second_key_error_reg <= 1'b1;
    end
  end

  //--------------------------------------------------------------
  // Event flag, sticky until reset
  //--------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      watchdog_event_reg <= 1'b0;
    end
    else if (event_cause)
    begin
      watchdog_event_reg <= 1'b1;
    end
  end

  //--------------------------------------------------------------
  // Fetch counter
  //--------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      fetch_count_reg <= fetch_watchdog_pkg::COUNT_RESET;
    end
    else if (good_clear)
    begin
      fetch_count_reg <= fetch_watchdog_pkg::COUNT_RESET;
    end
    else if (count_step)
    begin
      fetch_count_reg <= fetch_count_inc;
    end
  end

  //--------------------------------------------------------------
  // Hold register
  //--------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      held_upper_count_reg <= fetch_watchdog_pkg::HOLD_RESET;
    end
    else if (count_read)
    begin
      held_upper_count_reg <= fetch_count_reg[31:16];
    end
  end

  //--------------------------------------------------------------
  // Reset request pulse
  //--------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      reset_request_reg <= 1'b0;
    end
    else
    begin
      reset_request_reg <= event_cause && !watchdog_event_reg;
    end
  end

  //--------------------------------------------------------------
  // Key readback words
  //--------------------------------------------------------------
  always_comb
  begin
    first_key_word = 16'h0000;
    first_key_word[fetch_watchdog_pkg::FIRST_KEY_LSB +: 8] = first_key_field_reg;
    second_key_word = 16'h0000;
    second_key_word[fetch_watchdog_pkg::SECOND_KEY_LSB +: 8] = second_key_field_reg;
  end

  //--------------------------------------------------------------
  // Status word
  //--------------------------------------------------------------
  always_comb
  begin
    status_word = 16'h0000;
    status_word[fetch_watchdog_pkg::STAT_FIRST_ERR_BIT] = first_key_error_reg;
    status_word[fetch_watchdog_pkg::STAT_SECOND_ERR_BIT] = second_key_error_reg;
    status_word[fetch_watchdog_pkg::STAT_EVENT_BIT] = watchdog_event_reg;
    status_word[fetch_watchdog_pkg::STAT_WINDOW_BIT] = i_clear_window_open;
  end

  //--------------------------------------------------------------
  // Read select, zero when no read
  //--------------------------------------------------------------
  always_comb
  begin
    rdata_next = 16'h0000;
    if (i_rd)
    begin
      case (i_addr)
        fetch_watchdog_pkg::ADDR_FIRST_KEY:
        begin
          rdata_next = first_key_word;
        end
        fetch_watchdog_pkg::ADDR_CLEAR_KEY:
        begin
          rdata_next = second_key_word;
        end
        fetch_watchdog_pkg::ADDR_STATUS:
        begin
          rdata_next = status_word;
        end
        fetch_watchdog_pkg::ADDR_COUNT_LOW:
        begin
          rdata_next = fetch_count_reg[15:0];
        end
        fetch_watchdog_pkg::ADDR_COUNT_HIGH:
        begin
          rdata_next = fetch_count_reg[31:16];
        end
        fetch_watchdog_pkg::ADDR_TIMEOUT_LOW:
        begin
          rdata_next = timeout_config_value[15:0];
        end
        fetch_watchdog_pkg::ADDR_TIMEOUT_HIGH:
        begin
          rdata_next = timeout_config_value[31:16];
        end
        fetch_watchdog_pkg::ADDR_WINDOW_LOW:
        begin
          rdata_next = window_config_value[15:0];
        end
        fetch_watchdog_pkg::ADDR_WINDOW_HIGH:
        begin
          rdata_next = window_config_value[31:16];
        end
        fetch_watchdog_pkg::ADDR_HOLD:
        begin
          rdata_next = held_upper_count_reg;
        end
        default:
        begin
          rdata_next = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rdata_reg <= 16'h0000;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_reset_request = reset_request_reg;
  assign o_watchdog_event = watchdog_event_reg;

endmodule : fetch_watchdog

// >>> fetch_watchdog_props.sv
// Checker for the fetch watchdog ports
`timescale 1ns/1ps
module fetch_watchdog_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_fetch,
  input wire logic i_clear_window_open,
  input wire logic [15:0] i_timeout_fuse_low,
  input wire logic [15:0] i_timeout_fuse_high,
  input wire logic [15:0] i_window_fuse_low,
  input wire logic [15:0] i_window_fuse_high,
  input wire logic [15:0] o_rdata,
  input wire logic o_reset_request,
  input wire logic o_watchdog_event
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence stat_rd_s;
    i_rd && i_addr == fetch_watchdog_pkg::ADDR_STATUS;
  endsequence
  sequence bad_first_s;
    i_wr && i_addr == fetch_watchdog_pkg::ADDR_FIRST_KEY && i_wdata[15:8] != fetch_watchdog_pkg::FIRST_KEY_VALUE;
  endsequence
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000) else $error("data not idle");
  a_window_bit: assert property (stat_rd_s |=> o_rdata[0] == $past(i_clear_window_open)) else $error("window");
  a_event_shown: assert property (stat_rd_s ##0 o_watchdog_event |=> o_rdata[5]) else $error("event bit");
  a_bad_event: assert property (bad_first_s |=> o_watchdog_event) else $error("no event");
  a_first_flag: assert property (bad_first_s ##[1:8] stat_rd_s |=> o_rdata[7]) else $error("first flag");
  a_event_sticky: assert property (o_watchdog_event |=> o_watchdog_event) else $error("event lost");
  a_request_once: assert property (o_reset_request |-> $rose(o_watchdog_event) ##1 !o_reset_request) else $error("req");
  a_request_rise: assert property ($rose(o_watchdog_event) |-> o_reset_request) else $error("no req");
endmodule : fetch_watchdog_props

bind fetch_watchdog fetch_watchdog_props i_props (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_fetch,
  .i_clear_window_open, .i_timeout_fuse_low, .i_timeout_fuse_high, .i_window_fuse_low, .i_window_fuse_high,
  .o_rdata, .o_reset_request, .o_watchdog_event);

// >>> tb_fetch_watchdog.sv
// Testbench for the fetch watchdog
`timescale 1ns/1ps
module tb_fetch_watchdog;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_fetch = 0, i_clear_window_open = 0;
  logic o_reset_request, o_watchdog_event;
  logic [3:0] i_addr = 0;
  logic [15:0] i_wdata = 0, o_rdata, k;
  logic [15:0] cfg [4] = '{default: 16'h0000};
  logic [31:0] seed = 32'h631499e1, r;
  int bad_count = 0, compares = 0, n;
  fetch_watchdog i_dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_fetch, .i_clear_window_open,
    .i_timeout_fuse_low(cfg[0]), .i_timeout_fuse_high(cfg[1]), .i_window_fuse_low(cfg[2]),
    .i_window_fuse_high(cfg[3]), .o_rdata, .o_reset_request, .o_watchdog_event);
  initial forever #2.5 i_clk = ~i_clk;
  initial #100000 results(1);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic [15:0] stat(logic b1, logic b2, logic ev);
    return {8'h00, b1, b2, ev, 4'h0, i_clear_window_open};
  endfunction : stat
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Write when w is high, else read and compare with d
  task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk) {i_wr, i_rd} <= {w, !w};
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk) {i_wr, i_rd} <= 2'b00;
    #1;
    if (!w) check(o_rdata, d);
  endtask : bus
  task rst();
    i_rst <= 1;
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
  endtask : rst
  task fet(input int m, input logic all);
    n = 0;
    repeat (m)
    begin
      @(posedge i_clk) r = rnd();
      i_fetch <= r[1] | all;
      i_clear_window_open <= r[2];
      n += int'(r[1] | all);
    end
    @(posedge i_clk) i_fetch <= 0;
  endtask : fet
  task results(input int extra);
    bad_count += extra;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial
  begin
    r = rnd();
    cfg = '{r[15:0], r[31:16] | 16'h8000, ~r[15:0], ~r[31:16]};
    rst();
    bus(1, fetch_watchdog_pkg::ADDR_STATUS, 16'hffff);
    bus(0, fetch_watchdog_pkg::ADDR_STATUS, stat(0, 0, 0));
    check({15'h0000, o_watchdog_event}, 16'h0000);
    bus(0, 4'hf, 16'h0000);
    for (int i = 0; i < 4; i++)
      bus(0, fetch_watchdog_pkg::ADDR_TIMEOUT_LOW + 4'(i), cfg[i]);
    fet(40, 0);
    bus(0, fetch_watchdog_pkg::ADDR_COUNT_LOW, n[15:0]);
    bus(0, fetch_watchdog_pkg::ADDR_COUNT_HIGH, 16'h0000);
    bus(0, fetch_watchdog_pkg::ADDR_HOLD, 16'h0000);
    bus(1, fetch_watchdog_pkg::ADDR_FIRST_KEY, 16'h4000);
    bus(1, fetch_watchdog_pkg::ADDR_CLEAR_KEY, 16'h0008);
    bus(0, fetch_watchdog_pkg::ADDR_COUNT_LOW, 16'h0000);
    bus(0, fetch_watchdog_pkg::ADDR_FIRST_KEY, 16'h0000);
    bus(1, fetch_watchdog_pkg::ADDR_FIRST_KEY, 16'h4000);
    r = rnd();
    k = (r[7:0] == 8'h08) ? 16'h0009 : {8'h00, r[7:0]};
    bus(1, fetch_watchdog_pkg::ADDR_CLEAR_KEY, k);
    check({15'h0000, o_reset_request}, 16'h0001);
    check({15'h0000, o_watchdog_event}, 16'h0001);
    bus(0, fetch_watchdog_pkg::ADDR_STATUS, stat(0, 1, 1));
    check({15'h0000, o_reset_request}, 16'h0000);
    bus(0, fetch_watchdog_pkg::ADDR_CLEAR_KEY, 16'h0000);
    rst();
    k = {(r[15:8] == 8'h40) ? 8'h41 : r[15:8], 8'h00};
    bus(1, fetch_watchdog_pkg::ADDR_FIRST_KEY, k);
    bus(0, fetch_watchdog_pkg::ADDR_STATUS, stat(1, 0, 1));
    @(posedge i_clk);
    cfg[0] <= {12'h000, r[19:16]} + 16'h0003;
    cfg[1] <= 16'h0000;
    rst();
    fet(30, 1);
    bus(0, fetch_watchdog_pkg::ADDR_COUNT_LOW, cfg[0]);
    bus(0, fetch_watchdog_pkg::ADDR_STATUS, stat(0, 0, 1));
    results(0);
  end
endmodule : tb_fetch_watchdog
